// [i2c_scl_defs.svh]
/*
 * Constants for the fast-mode SCL phase count registers: offsets, reset values,
 * minimum counts and field widths.
 * Assumes it is included by bare name from files that need these numbers.
 */
`ifndef I2C_SCL_DEFS_SVH
`define I2C_SCL_DEFS_SVH

`define ADDR_W          8
`define DATA_W          32
`define CNT_W           14
`define PAD_W           18
`define FS_HIGH_OFFSET  8'h1c
`define FS_LOW_OFFSET   8'h20
`define FS_HIGH_RESET   14'h0006
`define FS_LOW_RESET    14'h0082
`define FS_HIGH_MIN     14'h0006
`define FS_LOW_MIN      14'h0008
`define PAD_ZERO        18'h0_0000
`define WORD_ZERO       32'h0000_0000
`define CNT_ONE         14'h0001
`define BYTE0_LO        0
`define BYTE1_LO        8
`define BYTE1_HI        13
`define STRB_BYTE0      0
`define STRB_BYTE1      1

`endif

// [i2c_scl_pkg.sv]
/*
 * Types shared by the fast-mode SCL count registers and the phase timer.
 * Assumes the constants header is available for widths.
 */
`include "i2c_scl_defs.svh"

package i2c_scl_pkg;

	typedef logic [`CNT_W-1:0] phase_count_t;

	typedef enum logic [1:0] {
		PHASE_IDLE,
		PHASE_HIGH,
		PHASE_LOW
	} scl_phase_t;

endpackage

// [scl_timing_if.sv]
/*
 * Carrier between the register block and the SCL phase timer.
 * Assumes both ends run on the same clock and reset.
 */
`timescale 1ns/1ps

interface scl_timing_if;

	logic                      run;
	i2c_scl_pkg::phase_count_t high_count;
	i2c_scl_pkg::phase_count_t low_count;
	logic                      scl_level;
	logic                      busy;

	modport regs  (output run, output high_count, output low_count, input scl_level, input busy);
	modport timer (input run, input high_count, input low_count, output scl_level, output busy);

endinterface

// [scl_phase_timer.sv]
/*
 * SCL phase timer: holds SCL high for high_count cycles, then low for
 * low_count cycles, repeating while run is asserted.
 * Assumes counts are already clamped to their minimums by the register block.
 */
`timescale 1ns/1ps
`include "i2c_scl_defs.svh"

module scl_phase_timer (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_i,
	scl_timing_if.timer       bus
);

	i2c_scl_pkg::scl_phase_t   phase;
	i2c_scl_pkg::scl_phase_t   next_phase;
	i2c_scl_pkg::phase_count_t count;
	i2c_scl_pkg::phase_count_t next_count;
	wire logic                 high_done;
	wire logic                 low_done;

	// Phase ends once the cycle count reaches the programmed length
	assign high_done = (count >= bus.high_count);
	assign low_done  = (count >= bus.low_count);

	// Next phase and count selection
	always_comb begin
		next_phase = phase;
		next_count = count + `CNT_ONE;
		unique case (phase)
			i2c_scl_pkg::PHASE_IDLE: begin
				next_count = `CNT_ONE;
				if (bus.run) begin
					next_phase = i2c_scl_pkg::PHASE_HIGH;
				end
			end
			i2c_scl_pkg::PHASE_HIGH: begin
				if (high_done) begin
					next_phase = i2c_scl_pkg::PHASE_LOW;
					next_count = `CNT_ONE;
				end
			end
			i2c_scl_pkg::PHASE_LOW: begin
				if (low_done) begin
					next_phase = i2c_scl_pkg::PHASE_HIGH;
					next_count = `CNT_ONE;
				end
			end
			default: begin
				next_phase = i2c_scl_pkg::PHASE_IDLE;
				next_count = `CNT_ONE;
			end
		endcase
		if (!bus.run) begin
			next_phase = i2c_scl_pkg::PHASE_IDLE;
			next_count = `CNT_ONE;
		end
	end

	// State, count and registered SCL level
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			phase         <= i2c_scl_pkg::PHASE_IDLE;
			count         <= `CNT_ONE;
			bus.scl_level <= 1'b1;
			bus.busy      <= 1'b0;
		end else begin
			phase         <= next_phase;
			count         <= next_count;
			bus.scl_level <= (next_phase != i2c_scl_pkg::PHASE_LOW);
			bus.busy      <= (next_phase != i2c_scl_pkg::PHASE_IDLE);
		end
	end

endmodule

// [i2c_fast_scl_regs.sv]
/*
 * Fast-mode SCL high and low phase count registers on the APB register port,
 * with the SCL phase timer that they steer.
 * Assumes the controller supplies its enable bit and the current speed and
 * sequence type; standard and high-speed timing live elsewhere.
 */
`timescale 1ns/1ps
`include "i2c_scl_defs.svh"

// Summary of operation
// - Fast high count times SCL high phase in fast and fast-plus modes.
// - Master code, START BYTE and general call use the fast counts.
// - High count accepts writes only while controller enable bit is 0.
// - High count written below 6 is stored as 6.
// - Low count writes while enabled are ignored, value kept.
// - Low count written below 8 is stored as 8.
// - Low count sits at offset 0x20 and resets to 0x82.
module i2c_fast_scl_regs (
	input  wire logic              sys_clk_i,
	input  wire logic              rst_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [`ADDR_W-1:0] paddr_i,
	input  wire logic [`DATA_W-1:0] pwdata_i,
	input  wire logic [3:0]        pstrb_i,
	input  wire logic              ctrl_enable_i,
	input  wire logic              fast_mode_i,
	input  wire logic              special_seq_i,
	input  wire logic              scl_run_i,
	output logic [`DATA_W-1:0]     prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	output logic [`CNT_W-1:0]      fast_high_count_o,
	output logic [`CNT_W-1:0]      fast_low_count_o,
	output logic                   scl_o,
	output logic                   timing_active_o
);

	scl_timing_if timing ();

	i2c_scl_pkg::phase_count_t fast_scl_high_count;
	i2c_scl_pkg::phase_count_t fast_scl_low_count;
	i2c_scl_pkg::phase_count_t next_high;
	i2c_scl_pkg::phase_count_t next_low;
	wire logic                 setup_phase;
	wire logic                 access_write;
	wire logic                 hit_high;
	wire logic                 hit_low;
	wire logic                 hit_any;
	wire logic                 write_allowed;
	wire logic [`DATA_W-1:0]   read_word;

	// Byte-lane merge of a write into the stored count field
	function automatic i2c_scl_pkg::phase_count_t merge_bytes(
		input i2c_scl_pkg::phase_count_t old_val,
		input logic [`DATA_W-1:0]        wdata,
		input logic [3:0]                strb
	);
		i2c_scl_pkg::phase_count_t val;
		val = old_val;
		if (strb[`STRB_BYTE0]) begin
			val[`BYTE1_LO-1:`BYTE0_LO] = wdata[`BYTE1_LO-1:`BYTE0_LO];
		end
		if (strb[`STRB_BYTE1]) begin
			val[`BYTE1_HI:`BYTE1_LO] = wdata[`BYTE1_HI:`BYTE1_LO];
		end
		return val;
	endfunction

	// Raise a value below the floor up to the floor
	function automatic i2c_scl_pkg::phase_count_t clamp_min(
		input i2c_scl_pkg::phase_count_t val,
		input i2c_scl_pkg::phase_count_t floor_val
	);
		return (val < floor_val) ? floor_val : val;
	endfunction

	// APB phase and address decode
	assign setup_phase   = psel_i && !penable_i;
	assign access_write  = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
	assign hit_high      = (paddr_i == `FS_HIGH_OFFSET);
	assign hit_low       = (paddr_i == `FS_LOW_OFFSET);
	assign hit_any       = hit_high || hit_low;
	assign write_allowed = !ctrl_enable_i;

	// Clamped candidate values; a refused write keeps the old value
	assign next_high = (access_write && hit_high && write_allowed) ?
		clamp_min(merge_bytes(fast_scl_high_count, pwdata_i, pstrb_i), `FS_HIGH_MIN) :
		fast_scl_high_count;
	assign next_low  = (access_write && hit_low && write_allowed) ?
		clamp_min(merge_bytes(fast_scl_low_count, pwdata_i, pstrb_i), `FS_LOW_MIN) :
		fast_scl_low_count;

	// Read mux with reserved upper bits at zero
	assign read_word = hit_high ? {`PAD_ZERO, fast_scl_high_count} :
		hit_low ? {`PAD_ZERO, fast_scl_low_count} : `WORD_ZERO;

	// Count registers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			fast_scl_high_count <= `FS_HIGH_RESET;
			fast_scl_low_count  <= `FS_LOW_RESET;
		end else begin
			fast_scl_high_count <= next_high;
			fast_scl_low_count  <= next_low;
		end
	end

	// APB answer: ready and error prepared in setup, one wait-free access
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= `WORD_ZERO;
		end else begin
			pready_o  <= setup_phase;
			pslverr_o <= setup_phase && !hit_any;
			prdata_o  <= (setup_phase && !pwrite_i) ? read_word : `WORD_ZERO;
		end
	end

	// Fast counts drive the timer in fast modes and special sequences
	assign timing.run        = scl_run_i && (fast_mode_i || special_seq_i);
	assign timing.high_count = fast_scl_high_count;
	assign timing.low_count  = fast_scl_low_count;

	scl_phase_timer u_timer (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.bus       (timing.timer)
	);

	// Registered copies of the counts and timer state
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			fast_high_count_o <= `FS_HIGH_RESET;
			fast_low_count_o  <= `FS_LOW_RESET;
			scl_o             <= 1'b1;
			timing_active_o   <= 1'b0;
		end else begin
			fast_high_count_o <= fast_scl_high_count;
			fast_low_count_o  <= fast_scl_low_count;
			scl_o             <= timing.scl_level;
			timing_active_o   <= timing.busy;
		end
	end

endmodule

// [scl_regs_checker.sv]
/* Assertions on the fast SCL count register ports.
   Assumes it is bound onto every instance of i2c_fast_scl_regs. */
`timescale 1ns/1ps
`include "i2c_scl_defs.svh"
module scl_regs_checker (
	input wire logic               sys_clk_i,
	input wire logic               rst_i,
	input wire logic               psel_i,
	input wire logic               penable_i,
	input wire logic               pwrite_i,
	input wire logic [`ADDR_W-1:0] paddr_i,
	input wire logic [`DATA_W-1:0] pwdata_i,
	input wire logic [3:0]         pstrb_i,
	input wire logic               ctrl_enable_i,
	input wire logic [`DATA_W-1:0] prdata_o,
	input wire logic               pready_o,
	input wire logic               pslverr_o,
	input wire logic [`CNT_W-1:0]  fast_high_count_o,
	input wire logic [`CNT_W-1:0]  fast_low_count_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Write seen at the access edge, locked or free, full field strobed
	wire       wr_hit = psel_i & penable_i & pready_o & pwrite_i;
	wire       wr_ok  = wr_hit & ~ctrl_enable_i & (pstrb_i[1:0] == 2'b11);
	wire       to_hi  = paddr_i == `FS_HIGH_OFFSET;
	wire       to_lo  = paddr_i == `FS_LOW_OFFSET;
	high_lock_a: assert property (wr_hit & ctrl_enable_i & to_hi |-> ##2 $stable(fast_high_count_o))
		else $error("high count changed while enabled");
	low_lock_a: assert property (wr_hit & ctrl_enable_i & to_lo |-> ##2 $stable(fast_low_count_o))
		else $error("low count changed while enabled");
	high_clamp_a: assert property (wr_ok & to_hi |-> ##2 fast_high_count_o ==
		(($past(pwdata_i[13:0], 2) < `FS_HIGH_MIN) ? `FS_HIGH_MIN : $past(pwdata_i[13:0], 2))) else $error("high store");
	low_clamp_a: assert property (wr_ok & to_lo |-> ##2 fast_low_count_o ==
		(($past(pwdata_i[13:0], 2) < `FS_LOW_MIN) ? `FS_LOW_MIN : $past(pwdata_i[13:0], 2))) else $error("low store");
	low_floor_a: assert property (fast_low_count_o >= `FS_LOW_MIN) else $error("low count under floor");
	unmapped_err_a: assert property (pready_o & ~to_hi & ~to_lo |-> pslverr_o) else $error("unmapped without error");
	upper_zero_a: assert property (prdata_o[31:14] == `PAD_ZERO) else $error("upper read bits set");
	low_reset_a: assert property ($fell(rst_i) |-> fast_low_count_o == `FS_LOW_RESET) else $error("low reset");
	cover property (wr_ok & to_lo);
	cover property (wr_hit & ctrl_enable_i);
	cover property (pslverr_o);
endmodule
bind i2c_fast_scl_regs scl_regs_checker u_scl_regs_checker (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
	.paddr_i, .pwdata_i, .pstrb_i, .ctrl_enable_i, .prdata_o, .pready_o, .pslverr_o, .fast_high_count_o,
	.fast_low_count_o);

// [scl_listener.sv]
/* Far-side bus device model: times each SCL phase it sees.
   Assumes SCL is sampled on the system clock. */
`timescale 1ns/1ps
module scl_listener (
	input  wire logic  sys_clk_i,
	input  wire logic  scl_i,
	output logic [15:0] high_len_o,
	output logic [15:0] low_len_o
);
	logic [15:0] run;
	logic        last;
	// Run length restarts on each edge of SCL, latched when the phase ends
	always_ff @(posedge sys_clk_i) begin
		last <= scl_i;
		run <= (scl_i != last) ? 16'h0001 : run + 16'h0001;
		if (last & ~scl_i) high_len_o <= run;
		if (~last & scl_i) low_len_o <= run;
	end
endmodule

// [test_i2c_fast_scl_regs.sv]
/* Self-checking bench for the fast SCL count registers.
   Assumes the listener model watches scl_o. */
`timescale 1ns/1ps
module test_i2c_fast_scl_regs;
	logic        sys_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o, scl_o, er;
	logic        ctrl_enable_i = 0, fast_mode_i = 0, special_seq_i = 0, scl_run_i = 0, timing_active_o;
	logic [7:0]  paddr_i = 0;
	logic [3:0]  pstrb_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, rd;
	logic [15:0] hl, ll;
	logic [13:0] hc, lc;
	int          err_count = 0, checked = 0, cyc = 0, n;
	always #10 sys_clk_i = ~sys_clk_i;
	i2c_fast_scl_regs u_i2c_fast_scl_regs (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .pstrb_i, .ctrl_enable_i, .fast_mode_i, .special_seq_i, .scl_run_i, .prdata_o, .pready_o,
		.pslverr_o, .fast_high_count_o(hc), .fast_low_count_o(lc), .scl_o, .timing_active_o);
	scl_listener u_scl_listener (.sys_clk_i, .scl_i(scl_o), .high_len_o(hl), .low_len_o(ll));
	task close_out;
		if (err_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until ready is seen at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(negedge sys_clk_i);
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} = {2'b10, w, a, d, s};
		@(negedge sys_clk_i);
		penable_i = 1;
		n = 0;
		do begin @(posedge sys_clk_i); n++; end while (pready_o !== 1'b1 && n < 8);
		rd = prdata_o;
		er = pslverr_o;
		chk({31'h0, pready_o}, 32'h0000_0001);
		@(negedge sys_clk_i);
		{psel_i, penable_i} = 2'b00;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 32'h0000_0000, 4'h0);
		chk(rd, e);
	endtask
	task t_reset;
		rd_chk(8'h20, 32'h0000_0082);
		rd_chk(8'h1c, 32'h0000_0006);
		chk({18'h0, hc}, 32'h0000_0006);
		chk({18'h0, lc}, 32'h0000_0082);
	endtask
	task t_clamp;
		apb(1, 8'h1c, 32'hffff_c003, 4'hf);
		rd_chk(8'h1c, 32'h0000_0006);
		apb(1, 8'h20, 32'h0000_0005, 4'hf);
		rd_chk(8'h20, 32'h0000_0008);
		apb(1, 8'h20, 32'h0000_000a, 4'h1);
		apb(1, 8'h20, 32'h0000_0100, 4'h2);
		rd_chk(8'h20, 32'h0000_010a);
		chk({18'h0, lc}, 32'h0000_010a);
		apb(1, 8'h30, 32'h0000_0001, 4'hf);
		chk({31'h0, er}, 32'h0000_0001);
	endtask
	task t_lock;
		ctrl_enable_i = 1;
		apb(1, 8'h1c, 32'h0000_0040, 4'hf);
		apb(1, 8'h20, 32'h0000_0040, 4'hf);
		rd_chk(8'h1c, 32'h0000_0006);
		rd_chk(8'h20, 32'h0000_010a);
		ctrl_enable_i = 0;
	endtask
	// Program counts while idle, then clock SCL and let the listener time it
	task t_run(input logic [31:0] h, input logic [31:0] l, input logic fm);
		{scl_run_i, fast_mode_i, special_seq_i, ctrl_enable_i} = 4'h0;
		apb(1, 8'h1c, h, 4'hf);
		apb(1, 8'h20, l, 4'hf);
		{scl_run_i, ctrl_enable_i} = 2'b11;
		repeat (6) @(negedge sys_clk_i);
		chk({31'h0, timing_active_o}, 32'h0000_0000);
		fast_mode_i = fm;
		special_seq_i = ~fm;
		repeat (90) @(negedge sys_clk_i);
		chk({16'h0, hl}, h);
		chk({16'h0, ll}, l);
		chk({31'h0, timing_active_o}, 32'h0000_0001);
	endtask
	// Reset in mid-run: counts and SCL return to their reset state
	task t_rerst;
		rst_i = 1;
		repeat (2) @(negedge sys_clk_i);
		rst_i = 0;
		chk({31'h0, scl_o}, 32'h0000_0001);
		chk({18'h0, hc}, 32'h0000_0006);
		rd_chk(8'h20, 32'h0000_0082);
	endtask
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			close_out;
		end
	end
	initial begin
		repeat (8) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		rst_i = 0;
		t_reset;
		t_clamp;
		t_lock;
		t_run(32'h0000_000a, 32'h0000_000c, 1'b1);
		t_run(32'h0000_0007, 32'h0000_0009, 1'b0);
		t_rerst;
		close_out;
	end
endmodule
